// File: hdl/hpcg_pkg.sv
// Package of constants and types for the host packet checksum gate.
// What this block does
// - Every exchange is a full-duplex 32-bit packet: 8-bit identifier, 24-bit payload.
// - Host lowers select, waits for ready low, shifts packet, raises select.
// - With a packet pending for the host, the device pulls ready low.
// - Enabled with nothing queued, the device answers with a status packet.
// - The upper eight received bits are the identifier used for dispatch.
// - Identifiers 00 to 06 decode to checksum and setup packet kinds, 0F to the receive line kind.
// - Identifiers 10 to 1B decode as twelve receiver control settings.
// - Identifiers 1C to 1F are ignored and never enter the checksum.
// - Identifiers 20 to 27 assign frames, 20 covering 112 to 127.
// - Identifier 78 enables user addresses; 80 to 8F assign addresses 0 to 15.
// - Outgoing identifiers 00 block info, 01 address, 02 to 57 word number.
// - Outgoing 60 roaming, 7E shutdown, 7F status, FF part identity only.
// - Packets shift most significant bit first; packet bit 31 goes first.
// - Payloads of accumulated packets XOR into the checksum register.
// - Reset disables the device and loads the part identity into the checksum.
// - Each accumulated packet stores the XOR result and disables the device.
// - A matching checksum packet while disabled enables the device.
// - A checksum packet while enabled is ignored.
// - While disabled only the part identity packet goes out, and ready prompts it.
// - Disabled only blocks reading; decoding continues.
// - Checksum packet: identifier 0 in byte 3, value in bytes 2 to 0.
package hpcg_pkg;
   localparam int PKT_W = 32;
   localparam int ID_W  = 8;
   localparam int PAY_W = 24;
   localparam int CNT_W = 5;
   // Arbitrary neutral part identity value.
   localparam logic [23:0] PART_ID_VAL = 24'h00A5C3;
   // Host-to-device identifiers.
   localparam logic [7:0] ID_CHECKSUM  = 8'h00;
   localparam logic [7:0] ID_TIMING    = 8'h06;
   localparam logic [7:0] ID_RXLINE    = 8'h0F;
   localparam logic [7:0] ID_RXCTL_LO  = 8'h10;
   localparam logic [7:0] ID_RXCTL_HI  = 8'h1B;
   localparam logic [7:0] ID_SPEC_LO   = 8'h1C;
   localparam logic [7:0] ID_SPEC_HI   = 8'h1F;
   localparam logic [7:0] ID_FRAME_LO  = 8'h20;
   localparam logic [7:0] ID_FRAME_HI  = 8'h27;
   localparam logic [7:0] ID_UADDR_EN  = 8'h78;
   localparam logic [7:0] ID_UADDR_LO  = 8'h80;
   localparam logic [7:0] ID_UADDR_HI  = 8'h8F;
   // Device-to-host identifiers.
   localparam logic [7:0] OID_WORD_HI  = 8'h57;
   localparam logic [7:0] OID_ROAM     = 8'h60;
   localparam logic [7:0] OID_SHUTDOWN = 8'h7E;
   localparam logic [7:0] OID_STATUS   = 8'h7F;
   localparam logic [7:0] OID_PART_ID  = 8'hFF;
   // Packet kinds presented with each received packet.
   typedef enum logic [3:0] {
      HPCG_K_NONE     = 4'h0,
      HPCG_K_CHECKSUM = 4'h1,
      HPCG_K_SETUP    = 4'h2,
      HPCG_K_RXLINE   = 4'h3,
      HPCG_K_RXCTL    = 4'h4,
      HPCG_K_FRAME    = 4'h5,
      HPCG_K_UADDR_EN = 4'h6,
      HPCG_K_UADDR    = 4'h7,
      HPCG_K_IGNORED  = 4'h8,
      HPCG_K_RESERVED = 4'h9
   } hpcg_kind_t;
endpackage

// File: hdl/hpcg_sync.sv
// Two-flop synchroniser for one pin input.
`timescale 1ns/100ps
`default_nettype none
module hpcg_sync
(
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic ce,
   // Data
   input  wire logic din,
   output var  logic dout
);
   typedef struct packed
   {
      logic s1_q;
      logic s2_q;
   } hpcg_sync_st_t;
   hpcg_sync_st_t st_q;
   hpcg_sync_st_t st_d;
   always_comb
   begin
      st_d = st_q;
      if (ce)
      begin
         st_d.s1_q = din;
         st_d.s2_q = st_q.s1_q;
      end
   end
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         st_q <= '0;
      else
         st_q <= st_d;
   end
   assign dout = st_q.s2_q;
endmodule
`default_nettype wire

// File: hdl/hpcg_decode.sv
// Identifier decoder for received host packets.
`timescale 1ns/100ps
`default_nettype none
module hpcg_decode
(
   // Identifier in
   input  wire logic [7:0]          id,
   // Decoded kind and index
   output var  hpcg_pkg::hpcg_kind_t kind,
   output var  logic [3:0]          index
);
   always_comb
   begin
      kind  = hpcg_pkg::HPCG_K_RESERVED;
      index = 4'h0;
      if (id == hpcg_pkg::ID_CHECKSUM)
         kind = hpcg_pkg::HPCG_K_CHECKSUM;
      else if (id <= hpcg_pkg::ID_TIMING)
      begin
         kind  = hpcg_pkg::HPCG_K_SETUP;
         index = id[3:0];
      end
      else if (id == hpcg_pkg::ID_RXLINE)
         kind = hpcg_pkg::HPCG_K_RXLINE;
      else if (id >= hpcg_pkg::ID_RXCTL_LO && id <= hpcg_pkg::ID_RXCTL_HI)
      begin
         kind  = hpcg_pkg::HPCG_K_RXCTL;
         index = id[3:0];
      end
      else if (id >= hpcg_pkg::ID_SPEC_LO && id <= hpcg_pkg::ID_SPEC_HI)
         kind = hpcg_pkg::HPCG_K_IGNORED;
      else if (id >= hpcg_pkg::ID_FRAME_LO && id <= hpcg_pkg::ID_FRAME_HI)
      begin
         // Index counts frame groups from the top: 0 covers frames 112 to 127.
         kind  = hpcg_pkg::HPCG_K_FRAME;
         index = id[3:0];
      end
      else if (id == hpcg_pkg::ID_UADDR_EN)
         kind = hpcg_pkg::HPCG_K_UADDR_EN;
      else if (id >= hpcg_pkg::ID_UADDR_LO && id <= hpcg_pkg::ID_UADDR_HI)
      begin
         kind  = hpcg_pkg::HPCG_K_UADDR;
         index = id[3:0];
      end
   end
endmodule
`default_nettype wire

// File: hdl/hpcg_top.sv
// Host packet port: SPI shifter, identifier dispatch and checksum gate.
`timescale 1ns/100ps
`default_nettype none
module hpcg_top
(
   // Clock, reset and enable
   input  wire logic        CORE_CLK,
   input  wire logic        RESETN,
   input  wire logic        CE,
   // SPI pins
   input  wire logic        SS_N,
   input  wire logic        SCK,
   input  wire logic        MOSI,
   output var  logic        MISO,
   output var  logic        READY_N,
   // Outgoing packet offer from the decoder core
   input  wire logic        TX_VALID,
   input  wire logic [31:0] TX_PACKET,
   output var  logic        TX_TAKEN,
   // Status packet payload supplied by the core
   input  wire logic [23:0] STATUS_PAYLOAD,
   // Received packet dispatch
   output var  logic        RX_STROBE,
   output var  logic [3:0]  RX_KIND,
   output var  logic [3:0]  RX_INDEX,
   output var  logic [23:0] RX_PAYLOAD,
   output var  logic        RX_DROPPED,
   // Gate state
   output var  logic        ENABLED,
   output var  logic [23:0] CHECKSUM_VALUE
);
   // Progress of the packet inside one select period.
   typedef enum logic [1:0]
   {
      HPCG_F_IDLE  = 2'b00,
      HPCG_F_SHIFT = 2'b01,
      HPCG_F_HOLD  = 2'b10
   } hpcg_frame_t;

   typedef struct packed
   {
      hpcg_frame_t                frame;
      logic                       ss_prev;
      logic                       sck_prev;
      logic [hpcg_pkg::CNT_W-1:0] bit_cnt;
      logic [hpcg_pkg::PKT_W-1:0] rx_sr;
      logic [hpcg_pkg::PKT_W-1:0] tx_sr;
      logic                       miso;
      logic                       ready_n;
      logic                       tx_taken;
      logic                       rx_strobe;
      logic [3:0]                 rx_kind;
      logic [3:0]                 rx_index;
      logic [hpcg_pkg::PAY_W-1:0] rx_payload;
      logic                       rx_dropped;
      logic                       enabled;
      logic [hpcg_pkg::PAY_W-1:0] checksum;
   } hpcg_top_st_t;

   // Edge detector history resets to the synchroniser reset level, so no false falling select edge follows reset.
   localparam hpcg_top_st_t ST_RST = '{
      frame    : HPCG_F_IDLE,
      ready_n  : 1'b1,
      checksum : hpcg_pkg::PART_ID_VAL,
      default  : '0
   };

   hpcg_top_st_t               st_q;
   hpcg_top_st_t               st_d;
   logic                       ss_n_s;
   logic                       sck_s;
   logic                       mosi_s;
   logic                       ss_fall;
   logic                       ss_rise;
   logic                       sck_rise;
   logic                       sck_fall;
   logic [hpcg_pkg::PKT_W-1:0] rx_word;
   logic [hpcg_pkg::ID_W-1:0]  rx_id;
   logic [hpcg_pkg::PAY_W-1:0] rx_pay;
   hpcg_pkg::hpcg_kind_t       rx_kind_w;
   logic [3:0]                 rx_index_w;
   logic                       last_bit;
   logic                       core_ok;
   logic                       pending;
   logic [hpcg_pkg::PKT_W-1:0] load_pkt;
   logic                       load_core;
   logic                       tx_id_legal;

   // Outgoing identifiers that may ever appear on the line.
   function automatic logic out_id_legal(input logic [hpcg_pkg::ID_W-1:0] id);
      return (id <= hpcg_pkg::OID_WORD_HI)
         || (id == hpcg_pkg::OID_ROAM)
         || (id == hpcg_pkg::OID_SHUTDOWN)
         || (id == hpcg_pkg::OID_STATUS)
         || (id == hpcg_pkg::OID_PART_ID);
   endfunction

   // The host owns all three pins, so each one is synchronised before use.
   hpcg_sync u_sync_ss
   (
      .clk   (CORE_CLK),
      .rst_n (RESETN),
      .ce    (CE),
      .din   (SS_N),
      .dout  (ss_n_s)
   );

   hpcg_sync u_sync_sck
   (
      .clk   (CORE_CLK),
      .rst_n (RESETN),
      .ce    (CE),
      .din   (SCK),
      .dout  (sck_s)
   );

   hpcg_sync u_sync_mosi
   (
      .clk   (CORE_CLK),
      .rst_n (RESETN),
      .ce    (CE),
      .din   (MOSI),
      .dout  (mosi_s)
   );

   assign ss_fall  = st_q.ss_prev & ~ss_n_s;
   assign ss_rise  = ~st_q.ss_prev & ss_n_s;
   assign sck_rise = ~st_q.sck_prev & sck_s;
   assign sck_fall = st_q.sck_prev & ~sck_s;

   // The word as it stands once the bit of this rising edge is shifted in.
   assign rx_word  = {st_q.rx_sr[hpcg_pkg::PKT_W-2:0], mosi_s};
   assign rx_id    = rx_word[hpcg_pkg::PKT_W-1 -: hpcg_pkg::ID_W];
   assign rx_pay   = rx_word[hpcg_pkg::PAY_W-1:0];
   assign last_bit = int'(st_q.bit_cnt) == hpcg_pkg::PKT_W - 1;

   hpcg_decode u_decode
   (
      .id    (rx_id),
      .kind  (rx_kind_w),
      .index (rx_index_w)
   );

   // A core offer with an identifier that may not go out is never taken.
   assign core_ok = TX_VALID
      && out_id_legal(TX_PACKET[hpcg_pkg::PKT_W-1 -: hpcg_pkg::ID_W])
      && (TX_PACKET[hpcg_pkg::PKT_W-1 -: hpcg_pkg::ID_W] != hpcg_pkg::OID_PART_ID);

   // While disabled the part identity is always waiting, so ready stays low as a prompt.
   assign pending = !st_q.enabled || core_ok;

   assign tx_id_legal = out_id_legal(st_q.tx_sr[hpcg_pkg::PKT_W-1 -: hpcg_pkg::ID_W]);

   // Packet loaded at the select edge; the gate decides what may be read.
   always_comb
   begin
      load_pkt  = {hpcg_pkg::OID_PART_ID, hpcg_pkg::PART_ID_VAL};
      load_core = 1'b0;
      if (st_q.enabled)
      begin
         if (core_ok)
         begin
            load_pkt  = TX_PACKET;
            load_core = 1'b1;
         end
         else
            load_pkt = {hpcg_pkg::OID_STATUS, STATUS_PAYLOAD};
      end
   end

   always_comb
   begin
      st_d = st_q;
      if (CE)
      begin
         st_d.ss_prev   = ss_n_s;
         st_d.sck_prev  = sck_s;
         st_d.rx_strobe = 1'b0;
         st_d.tx_taken  = 1'b0;
         case (st_q.frame)
            HPCG_F_IDLE:
            begin
               // Every packet needs a fresh falling select edge.
               if (ss_fall)
               begin
                  st_d.frame    = HPCG_F_SHIFT;
                  st_d.bit_cnt  = '0;
                  st_d.tx_sr    = load_pkt;
                  st_d.miso     = load_pkt[hpcg_pkg::PKT_W-1];
                  st_d.tx_taken = load_core;
               end
            end
            HPCG_F_SHIFT:
            begin
               // A select that rises early throws the partial packet away.
               if (ss_rise)
                  st_d.frame = HPCG_F_IDLE;
               else if (sck_rise)
               begin
                  st_d.rx_sr   = rx_word;
                  st_d.bit_cnt = st_q.bit_cnt + {{(hpcg_pkg::CNT_W-1){1'b0}}, 1'b1};
                  if (last_bit)
                  begin
                     // Dispatch is independent of the gate: only reading is blocked.
                     st_d.frame      = HPCG_F_HOLD;
                     st_d.rx_strobe  = 1'b1;
                     st_d.rx_kind    = rx_kind_w;
                     st_d.rx_index   = rx_index_w;
                     st_d.rx_payload = rx_pay;
                     st_d.rx_dropped = (rx_kind_w == hpcg_pkg::HPCG_K_IGNORED)
                        || (rx_kind_w == hpcg_pkg::HPCG_K_RESERVED);
                     case (rx_kind_w)
                        hpcg_pkg::HPCG_K_CHECKSUM:
                        begin
                           if (!st_q.enabled && (rx_pay == st_q.checksum))
                              st_d.enabled = 1'b1;
                        end
                        hpcg_pkg::HPCG_K_IGNORED:
                           st_d.enabled = st_q.enabled;
                        default:
                        begin
                           st_d.checksum = st_q.checksum ^ rx_pay;
                           st_d.enabled  = 1'b0;
                        end
                     endcase
                  end
               end
               else if (sck_fall)
               begin
                  st_d.tx_sr = {st_q.tx_sr[hpcg_pkg::PKT_W-2:0], 1'b0};
                  st_d.miso  = st_q.tx_sr[hpcg_pkg::PKT_W-2];
               end
            end
            HPCG_F_HOLD:
            begin
               // Extra clocks after the last bit are not taken as a new packet.
               if (ss_rise)
                  st_d.frame = HPCG_F_IDLE;
            end
            default:
               st_d.frame = HPCG_F_IDLE;
         endcase
         st_d.ready_n = !((st_d.frame != HPCG_F_IDLE) || pending);
      end
   end

   always_ff @(posedge CORE_CLK or negedge RESETN)
   begin
      if (!RESETN)
         st_q <= ST_RST;
      else
         st_q <= st_d;
   end

   assign MISO           = st_q.miso;
   assign READY_N        = st_q.ready_n;
   assign TX_TAKEN       = st_q.tx_taken;
   assign RX_STROBE      = st_q.rx_strobe;
   assign RX_KIND        = st_q.rx_kind;
   assign RX_INDEX       = st_q.rx_index;
   assign RX_PAYLOAD     = st_q.rx_payload;
   assign RX_DROPPED     = st_q.rx_dropped;
   assign ENABLED        = st_q.enabled;
   assign CHECKSUM_VALUE = st_q.checksum;

   // A select period opens and its packet has just been loaded.
   sequence seq_frame_start;
      (st_q.frame == HPCG_F_IDLE) ##1 (st_q.frame == HPCG_F_SHIFT);
   endsequence

   // The gate has been closed for two sampled cycles in a row.
   sequence seq_closed_two;
      !ENABLED ##1 !ENABLED;
   endsequence

   AST_STROBE_PULSE: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
      RX_STROBE && CE |=> !RX_STROBE)
      else $error("Dispatch strobe lasted more than one cycle.");

   AST_ACCUMULATE: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
      RX_STROBE && (RX_KIND != hpcg_pkg::HPCG_K_CHECKSUM) && (RX_KIND != hpcg_pkg::HPCG_K_IGNORED)
      |-> !ENABLED && (CHECKSUM_VALUE == ($past(CHECKSUM_VALUE) ^ RX_PAYLOAD)))
      else $error("Accumulated packet did not fold its payload or left the gate open.");

   AST_IGNORED_KEEPS: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
      RX_STROBE && (RX_KIND == hpcg_pkg::HPCG_K_IGNORED)
      |-> $stable(CHECKSUM_VALUE) && $stable(ENABLED))
      else $error("Ignored packet changed the checksum or the gate.");

   AST_MATCH_OPENS: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
      RX_STROBE && (RX_KIND == hpcg_pkg::HPCG_K_CHECKSUM) && !$past(ENABLED)
      |-> (ENABLED == (RX_PAYLOAD == CHECKSUM_VALUE)) && $stable(CHECKSUM_VALUE))
      else $error("Checksum packet while closed gave the wrong gate state.");

   AST_OPEN_IGNORES: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
      RX_STROBE && (RX_KIND == hpcg_pkg::HPCG_K_CHECKSUM) && $past(ENABLED)
      |-> ENABLED && $stable(CHECKSUM_VALUE))
      else $error("Checksum packet while open was not ignored.");

   AST_TAKEN_OPEN: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
      TX_TAKEN |-> ENABLED)
      else $error("Core packet taken while the gate was closed.");

   AST_PROMPT: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
      seq_closed_two |-> !READY_N)
      else $error("Ready did not prompt for the part identity while closed.");

   AST_LOAD_LEGAL: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
      seq_frame_start |-> tx_id_legal
         && (ENABLED || (st_q.tx_sr[hpcg_pkg::PKT_W-1 -: hpcg_pkg::ID_W] == hpcg_pkg::OID_PART_ID)))
      else $error("Loaded packet carries a forbidden identifier.");
endmodule
`default_nettype wire

// File: tb/hpcg_host.sv
// SPI host model that swaps 32-bit packets.
`timescale 1ns/100ps
`default_nettype none
module hpcg_host
(
   // SPI pins
   output var  logic ss_n,
   output var  logic sck,
   output var  logic mosi,
   input  wire logic miso,
   input  wire logic ready_n
);
   initial
   begin
      ss_n = 1'b1;
      sck = 1'b0;
      mosi = 1'b0;
   end
   task automatic xfer(input logic [31:0] tx, output logic [31:0] rx, output logic ok);
      int n;
      n = 0;
      ss_n = 1'b0;
      while (ready_n !== 1'b0 && n < 99)
      begin
         #40;
         n++;
      end
      ok = (n < 99);
      for (int i = 31; i >= 0; i--)
      begin
         mosi = tx[i];
         #160 sck = 1'b1;
         rx[i] = miso;
         #160 sck = 1'b0;
      end
      mosi = ~mosi;
      #160 ss_n = 1'b1;
      #320;
   endtask
endmodule
`default_nettype wire

// File: tb/hpcg_top_tb_top.sv
// Testbench of the host packet checksum gate.
`timescale 1ns/100ps
`default_nettype none
module hpcg_top_tb_top;
   logic        clk, rst_n, ss_n, sck, mosi, miso, rdy_n, tx_v, tkn, stb, drp, en, ok, seen;
   logic [31:0] tx_p, rx;
   logic [23:0] chk, pay, exp_cv, pw, pl;
   logic        dr, tks;
   logic [3:0]  kw, iw, knd, idx;
   int          error_cnt = 0, checked = 0, n;
   logic [11:0] rows [7] = '{12'h012, 12'h0F3, 12'h1B4, 12'h1C8, 12'h275, 12'h786, 12'h8F7};
   hpcg_top hpcg_top_i (.CORE_CLK(clk), .RESETN(rst_n), .CE(1'b1), .SS_N(ss_n), .SCK(sck), .MOSI(mosi),
      .MISO(miso), .READY_N(rdy_n), .TX_VALID(tx_v), .TX_PACKET(tx_p), .TX_TAKEN(tkn),
      .STATUS_PAYLOAD(24'h3C0F12), .RX_STROBE(stb), .RX_KIND(kw), .RX_INDEX(iw), .RX_PAYLOAD(pw),
      .RX_DROPPED(drp), .ENABLED(en), .CHECKSUM_VALUE(chk));
   hpcg_host hpcg_host_i (.ss_n(ss_n), .sck(sck), .mosi(mosi), .miso(miso), .ready_n(rdy_n));
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk)
   begin
      if (tkn === 1'b1)
         tks <= 1'b1;
      if (stb === 1'b1)
      begin
         seen <= 1'b1;
         knd <= kw;
         idx <= iw;
         dr <= drp;
         pl <= pw;
      end
   end
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string m);
      checked++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED %0t %s", $time, m);
      end
   endtask
   task automatic print_verdict();
      if (error_cnt == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // Waits a bounded time for the dispatch strobe so a hang ends the run.
   task automatic send(input logic [31:0] p);
      seen = 1'b0;
      hpcg_host_i.xfer(p, rx, ok);
      for (n = 0; seen !== 1'b1 && n < 20; n++)
         @(negedge clk);
      cmp({ok, seen}, 2'b11, "no ready or no strobe");
      if (ok !== 1'b1 || seen !== 1'b1)
         print_verdict();
   endtask
   initial
   begin
      rst_n = 1'b0;
      tx_v = 1'b0;
      tx_p = 32'h0;
      tks = 1'b0;
      repeat (10) @(negedge clk);
      rst_n = 1'b1;
      @(negedge clk);
      cmp({en, chk}, {1'b0, hpcg_pkg::PART_ID_VAL}, "reset state");
      send(32'h0);
      cmp({rx[31:24], en}, {8'hFF, 1'b0}, "part id or bad checksum");
      send({8'h00, hpcg_pkg::PART_ID_VAL});
      cmp(en, 1'b1, "enable");
      exp_cv = hpcg_pkg::PART_ID_VAL;
      foreach (rows[r])
      begin
         pay = 24'h5A0300 + r;
         send({rows[r][11:4], pay});
         if (rows[r][3:0] != 4'h8)
            exp_cv ^= pay;
         cmp(knd, rows[r][3:0], "kind");
         if (rows[r][3:0] == 4'h4 || rows[r][3:0] == 4'h7)
            cmp(idx, rows[r][7:4], "index");
         cmp({en, chk}, {1'b0, exp_cv}, "accumulate");
         cmp({dr, pl}, {rows[r][3:0] == 4'h8, pay}, "drop flag or payload");
      end
      send({8'h00, exp_cv});
      send(32'h0);
      cmp({en, chk}, {1'b1, exp_cv}, "checksum while enabled");
      cmp(rx, {8'h7F, 24'h3C0F12}, "status");
      tx_v = 1'b1;
      tx_p = {8'h60, 24'h123456};
      for (n = 0; rdy_n !== 1'b0 && n < 50; n++)
         @(negedge clk);
      cmp(rdy_n, 1'b0, "ready prompt");
      send(32'h0);
      @(negedge clk);
      tx_v = 1'b0;
      cmp(rx, tx_p, "offered packet");
      cmp(tks, 1'b1, "offer taken");
      print_verdict();
   end
endmodule
`default_nettype wire
